// ==== asb_map.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ASB_MAP_SVH
`define ASB_MAP_SVH
`define ASB_OFS_CTRL 12'h000
`define ASB_OFS_CONFIG 12'h004
`define ASB_OFS_SAMPLES 12'h008
`define ASB_OFS_REPEAT 12'h00C
`define ASB_OFS_LEVEL 12'h010
`define ASB_OFS_CLKDIV 12'h014
`define ASB_OFS_STATUS 12'h018
`define ASB_OFS_COUNT 12'h01C
`define ASB_OFS_REPCNT 12'h020
`define ASB_OFS_DATA 12'h024
`define ASB_OFS_RINGBACK 12'h028
`define ASB_CTRL_START 0
`define ASB_CTRL_STOP 1
`define ASB_CTRL_STATRST 2
`define ASB_CTRL_MEMRST 3
`define ASB_RST_CONFIG 8'h00
`define ASB_RST_SAMPLES 16'h0010
`define ASB_RST_REPEAT 16'h0001
`define ASB_RST_LEVEL 16'h8000
`define ASB_RST_CLKDIV 16'h0013
`define ASB_RST_RINGBACK 9'h001
`define ASB_ZERO_CODE 16'h8000
`define ASB_DEPTH 256
`define ASB_SYS_MHZ 20
`define ASB_CONV_TO_US 100
`define ASB_CONV_CYC (`ASB_CONV_TO_US * `ASB_SYS_MHZ)
`endif

// ==== asb_pkg.sv ====
// types shared by the acquisition buffer block
package asb_pkg;
    typedef enum logic [1:0] {ST_SW, ST_LEVEL, ST_EXT, ST_RSVD} asb_start_t;
    typedef enum {S_IDLE, S_WAIT, S_RUN} asb_state_t;
    // one finished conversion from the converter front end
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } asb_conv_t;
    // configuration word, low bits of CONFIG
    typedef struct packed {
        logic levelFall;
        logic extFall;
        asb_start_t startCond;
        logic ring;
    } asb_cfg_t;
    typedef struct packed {
        logic convErr;
        logic clkErr;
        logic overflow;
        logic stored;
        logic trigWait;
        logic operating;
    } asb_status_t;
endpackage

// ==== asb_top.sv ====
// acquisition control, sample buffer and status with an APB register port
`timescale 1ns/100ps
`include "asb_map.svh"
//==============================================================
// Behaviour
// - sampling begins only on the host start command
// - a stop command ends sampling at any moment
// - status and data reads allowed during sampling without disturbance
// - operating flag holds from start until done, error or stop
// - trigger-wait flag set for trigger or level start, cleared at trigger
// - trigger-wait set again on every re-entry to waiting when repeating
// - stored flag set when buffer holds the configured sample amount
// - FIFO: stored flag clears when reads drop below that amount
// - ring: stored flag stays set until reset
// - overflow flagged when writing a sample into a full buffer
// - overflow halts in FIFO; ring overwrites oldest and continues
// - clock error flagged when sample period outruns conversion
// - number of buffered items is readable
// - current repeat count is readable
// - FIFO reads return oldest first and free the read word
// - ring reads are relative to write position and keep data
// - samples are 16-bit unsigned, 32768 is zero volts
// - status reset clears clock error and conversion error
// - memory reset discards data, zeroes repeats, clears two flags
// - memory reset zeroes sampling count once sampling stops
// - any error halts sampling regardless of stop condition
module asb_top
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire asb_pkg::asb_conv_t convIn,
    output logic convStart,
    input wire logic trigPin,
    output asb_pkg::asb_status_t status
);
    import asb_pkg::*;

    localparam int AW = $clog2(`ASB_DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(`ASB_DEPTH);
    localparam logic [11:0] CONV_CYC = 12'(`ASB_CONV_CYC);

    //==========================================================
    // state
    logic [15:0] mem [0:`ASB_DEPTH-1];
    asb_state_t state, next_state;
    asb_cfg_t cfg, next_cfg;
    asb_status_t next_status;
    logic [15:0] samples, next_samples, repeatN, next_repeatN;
    logic [15:0] level, next_level, clkDiv, next_clkDiv;
    logic [15:0] divCnt, next_divCnt, sampCnt, next_sampCnt;
    logic [15:0] repCnt, next_repCnt, prevSample, next_prevSample;
    logic [AW:0] count, next_count, ringBack, next_ringBack;
    logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [11:0] convTimer, next_convTimer;
    logic convBusy, next_convBusy, pendClr, next_pendClr;
    logic next_convStart, next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic trigMeta, trigSync, trigLast;
    // helpers
    logic wrEn, rdEn, setup, ctrlWr, cmdStart, cmdStop, memRst, statRst;
    logic push, pop, halt, crossed, trigEdge, mapped;
    logic [AW-1:0] ringIdx;

    //==========================================================
    // trigger pin synchroniser, edge seen past second stage
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            trigMeta <= 1'b0;
            trigSync <= 1'b0;
            trigLast <= 1'b0;
        end
        else
        begin
            trigMeta <= trigPin;
            trigSync <= trigMeta;
            trigLast <= trigSync;
        end
    end

    // APB phase decode; completion is the edge where pready is seen
    assign setup = psel && penable && !pready;
    assign wrEn = psel && penable && pready && pwrite;
    assign rdEn = psel && penable && pready && !pwrite;
    assign ctrlWr = wrEn && paddr == `ASB_OFS_CTRL;
    assign cmdStart = ctrlWr && pwdata[`ASB_CTRL_START];
    assign cmdStop = ctrlWr && pwdata[`ASB_CTRL_STOP];
    assign statRst = ctrlWr && pwdata[`ASB_CTRL_STATRST];
    assign memRst = ctrlWr && pwdata[`ASB_CTRL_MEMRST];
    assign trigEdge = cfg.extFall ? (trigLast && !trigSync)
                                  : (!trigLast && trigSync);
    // level crossing between previous and current code
    assign crossed = cfg.levelFall
        ? (prevSample >= level && convIn.data < level)
        : (prevSample < level && convIn.data >= level);
    // ring reads look back from the write pointer, data is kept
    assign ringIdx = wrPtr - ringBack[AW-1:0];

    //==========================================================
    // acquisition, buffer and register next-state logic
    always_comb
    begin
        next_state = state;
        next_cfg = cfg;
        next_status = status;
        next_samples = samples;
        next_repeatN = repeatN;
        next_level = level;
        next_clkDiv = clkDiv;
        next_divCnt = divCnt;
        next_sampCnt = sampCnt;
        next_repCnt = repCnt;
        next_prevSample = prevSample;
        next_count = count;
        next_ringBack = ringBack;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_convTimer = convTimer;
        next_convBusy = convBusy;
        next_pendClr = pendClr;
        next_convStart = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        halt = 1'b0;
        // register writes
        if (wrEn)
        begin
            unique case (paddr)
                `ASB_OFS_CONFIG: next_cfg = asb_cfg_t'(pwdata[4:0]);
                `ASB_OFS_SAMPLES: next_samples = pwdata[15:0];
                `ASB_OFS_REPEAT: next_repeatN = pwdata[15:0];
                `ASB_OFS_LEVEL: next_level = pwdata[15:0];
                `ASB_OFS_CLKDIV: next_clkDiv = pwdata[15:0];
                `ASB_OFS_RINGBACK: next_ringBack = pwdata[AW:0];
                default: ;
            endcase
        end
        // sample clock divider, only while a run is armed
        if (state != S_IDLE)
        begin
            if (divCnt == 16'h0000)
            begin
                next_divCnt = clkDiv;
                if (convBusy)
                begin
                    next_status.clkErr = 1'b1;
                    halt = 1'b1;
                end
                else
                begin
                    next_convBusy = 1'b1;
                    next_convStart = 1'b1;
                    next_convTimer = 12'h000;
                end
            end
            else
                next_divCnt = divCnt - 16'h0001;
        end
        // conversion watchdog: a stuck converter is a conversion error
        if (convBusy && !convIn.valid)
        begin
            next_convTimer = convTimer + 12'h001;
            if (convTimer == CONV_CYC)
            begin
                next_status.convErr = 1'b1;
                halt = 1'b1;
            end
        end
        // finished conversion: wait for trigger or store
        if (convBusy && convIn.valid && !halt)
        begin
            next_convBusy = 1'b0;
            next_prevSample = convIn.data;
            if (state == S_WAIT && cfg.startCond == ST_LEVEL && crossed)
            begin
                next_state = S_RUN;
                next_status.trigWait = 1'b0;
            end
            if (state == S_RUN || next_state == S_RUN)
            begin
                push = 1'b1;
                if (count == FULL)
                begin
                    next_status.overflow = 1'b1;
                    if (!cfg.ring)
                    begin
                        push = 1'b0;
                        halt = 1'b1;
                    end
                    else
                        next_rdPtr = rdPtr + 1'b1;
                end
                if (push)
                begin
                    next_wrPtr = wrPtr + 1'b1;
                    if (sampCnt + 16'h0001 >= samples)
                    begin
                        next_sampCnt = 16'h0000;
                        next_repCnt = repCnt + 16'h0001;
                        if (repeatN != 16'h0000
                            && repCnt + 16'h0001 >= repeatN)
                            halt = 1'b1;
                        else if (cfg.startCond != ST_SW)
                        begin
                            next_state = S_WAIT;
                            next_status.trigWait = 1'b1;
                        end
                    end
                    else
                        next_sampCnt = sampCnt + 16'h0001;
                end
            end
        end
        // external trigger releases the wait
        if (state == S_WAIT && cfg.startCond == ST_EXT && trigEdge)
        begin
            next_state = S_RUN;
            next_status.trigWait = 1'b0;
        end
        // FIFO read removes the oldest word, ring read keeps it
        if (rdEn && paddr == `ASB_OFS_DATA && !cfg.ring
            && count != '0)
        begin
            pop = 1'b1;
            next_rdPtr = rdPtr + 1'b1;
        end
        if (push && count != FULL && !pop)
            next_count = count + 1'b1;
        else if (pop && !(push && count != FULL))
            next_count = count - 1'b1;
        // start command only from idle
        if (cmdStart && state == S_IDLE)
        begin
            next_status.operating = 1'b1;
            next_sampCnt = 16'h0000;
            next_divCnt = clkDiv;
            if (cfg.startCond == ST_SW)
                next_state = S_RUN;
            else
            begin
                next_state = S_WAIT;
                next_status.trigWait = 1'b1;
            end
        end
        // stop command or any terminating condition
        if (halt || (cmdStop && state != S_IDLE))
        begin
            next_state = S_IDLE;
            next_status.operating = 1'b0;
            next_status.trigWait = 1'b0;
            next_convBusy = 1'b0;
        end
        // error clear, a new error in this cycle wins
        if (statRst)
        begin
            next_status.clkErr = 1'b0;
            next_status.convErr = 1'b0;
            if (halt)
            begin
                next_status.clkErr = next_status.clkErr || divCnt == 0
                    && convBusy && state != S_IDLE;
                next_status.convErr = convBusy && !convIn.valid
                    && convTimer == CONV_CYC;
            end
        end
        // memory reset; new sample in the same cycle is dropped
        if (memRst)
        begin
            next_count = '0;
            next_rdPtr = wrPtr;
            next_wrPtr = wrPtr;
            next_repCnt = 16'h0000;
            next_status.overflow = 1'b0;
            next_pendClr = 1'b1;
        end
        // sampling count clears only once the run has stopped
        if (next_pendClr && next_state == S_IDLE)
        begin
            next_sampCnt = 16'h0000;
            next_pendClr = 1'b0;
        end
        // stored-amount flag
        if (samples != 16'h0000 && 17'(next_count) >= 17'(samples))
            next_status.stored = 1'b1;
        else if (!cfg.ring || memRst)
            next_status.stored = 1'b0;
    end

    //==========================================================
    // APB answer: one wait state, read data latched in it
    always_comb
    begin
        mapped = paddr[1:0] == 2'b00 && paddr <= `ASB_OFS_RINGBACK;
        next_pready = setup;
        next_pslverr = setup && !mapped;
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite)
        begin
            unique case (paddr)
                `ASB_OFS_CONFIG: next_prdata = {27'h0, cfg};
                `ASB_OFS_SAMPLES: next_prdata = {16'h0, samples};
                `ASB_OFS_REPEAT: next_prdata = {16'h0, repeatN};
                `ASB_OFS_LEVEL: next_prdata = {16'h0, level};
                `ASB_OFS_CLKDIV: next_prdata = {16'h0, clkDiv};
                `ASB_OFS_STATUS: next_prdata = {26'h0, status};
                `ASB_OFS_COUNT: next_prdata = 32'(count);
                `ASB_OFS_REPCNT: next_prdata = {16'h0, repCnt};
                `ASB_OFS_DATA: next_prdata = {16'h0,
                    cfg.ring ? mem[ringIdx] : mem[rdPtr]};
                `ASB_OFS_RINGBACK: next_prdata = 32'(ringBack);
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    //==========================================================
    // sample storage, no reset so it maps onto block memory
    always_ff @(posedge sys_clk)
    begin
        if (push && !memRst)
            mem[wrPtr] <= convIn.data;
    end

    // register stage for all control state
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state <= S_IDLE;
            cfg <= asb_cfg_t'(`ASB_RST_CONFIG);
            status <= '0;
            samples <= `ASB_RST_SAMPLES;
            repeatN <= `ASB_RST_REPEAT;
            level <= `ASB_RST_LEVEL;
            clkDiv <= `ASB_RST_CLKDIV;
            divCnt <= 16'h0000;
            sampCnt <= 16'h0000;
            repCnt <= 16'h0000;
            prevSample <= `ASB_ZERO_CODE;
            count <= '0;
            ringBack <= `ASB_RST_RINGBACK;
            wrPtr <= '0;
            rdPtr <= '0;
            convTimer <= 12'h000;
            convBusy <= 1'b0;
            pendClr <= 1'b0;
            convStart <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cfg <= next_cfg;
            status <= next_status;
            samples <= next_samples;
            repeatN <= next_repeatN;
            level <= next_level;
            clkDiv <= next_clkDiv;
            divCnt <= next_divCnt;
            sampCnt <= next_sampCnt;
            repCnt <= next_repCnt;
            prevSample <= next_prevSample;
            count <= next_count;
            ringBack <= next_ringBack;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            convTimer <= next_convTimer;
            convBusy <= next_convBusy;
            pendClr <= next_pendClr;
            convStart <= next_convStart;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    //==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    start_sets_op_a: assert property (
        cmdStart && state == S_IDLE && !cmdStop |=> status.operating)
        else $error("start did not raise operating");
    op_needs_start_a: assert property (
        $rose(status.operating) |-> $past(cmdStart))
        else $error("operating rose without start");
    stop_clears_op_a: assert property (
        cmdStop && !cmdStart |=> !status.operating && state == S_IDLE)
        else $error("stop did not end sampling");
    wait_on_trig_a: assert property (
        cmdStart && state == S_IDLE && !cmdStop && cfg.startCond != ST_SW
        |=> status.trigWait && state == S_WAIT)
        else $error("trigger wait not raised");
    fifo_ovf_halt_a: assert property (
        !cfg.ring && $rose(status.overflow) |-> !status.operating)
        else $error("fifo overflow did not halt");
    clk_err_halt_a: assert property (
        $rose(status.clkErr) |-> !status.operating && !convBusy)
        else $error("clock error did not halt");
    stat_rst_a: assert property (
        statRst && state == S_IDLE |=> !status.clkErr && !status.convErr)
        else $error("status reset left an error set");
    mem_rst_a: assert property (
        memRst |=> count == '0 && repCnt == 16'h0000 && !status.overflow)
        else $error("memory reset incomplete");
    fifo_pop_a: assert property (
        pop && !push && !memRst |=> count == $past(count) - 1'b1)
        else $error("fifo read did not free a word");
    ring_keep_a: assert property (
        cfg.ring && rdEn && !push && !memRst |=> count == $past(count))
        else $error("ring read changed the fill");
endmodule

// ==== asb_conv_model.sv ====
// behavioural converter front end that answers sample requests
`timescale 1ns/100ps
module asb_conv_model
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic convStart,
    input wire logic [7:0] latency,
    input wire logic mute,
    output asb_pkg::asb_conv_t convIn,
    output logic [15:0] seq
);
    import asb_pkg::*;
    logic busy;
    logic [7:0] waitCnt;
    //==============================================================
    // request latch and answer timing
    // a muted model never answers, so the block must time out on its own
    always_ff @(posedge sys_clk)
    begin
        convIn.valid <= 1'b0;
        convIn.data <= ~convIn.data; // idle data toggles, never looks held
        if (!rst_n)
        begin
            busy <= 1'b0;
            waitCnt <= 8'h00;
            seq <= 16'h0000;
        end
        else if (convStart)
        begin
            busy <= 1'b1;
            waitCnt <= latency;
        end
        else if (busy && waitCnt != 8'h00)
            waitCnt <= waitCnt - 8'h01;
        else if (busy && !mute)
        begin
            busy <= 1'b0;
            convIn.valid <= 1'b1;
            convIn.data <= 16'h8000 + seq;
            seq <= seq + 16'h0001;
        end
    end
endmodule

// ==== adc_sample_buffer_status_tb.sv ====
// self-checking bench for the acquisition buffer block
`timescale 1ns/100ps
`include "asb_map.svh"
module adc_sample_buffer_status_tb;
    import asb_pkg::*;
    logic sys_clk, rst_n, psel, penable, pwrite, trigPin, mute, pready;
    logic pslverr, convStart, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] latency;
    logic [15:0] seq, s0;
    asb_conv_t convIn;
    asb_status_t status;
    int failCount, testsRun, cycles, k;
    logic [11:0] rAddr [9] = '{`ASB_OFS_CONFIG, `ASB_OFS_SAMPLES,
        `ASB_OFS_REPEAT, `ASB_OFS_LEVEL, `ASB_OFS_CLKDIV, `ASB_OFS_STATUS,
        `ASB_OFS_COUNT, `ASB_OFS_REPCNT, `ASB_OFS_RINGBACK};
    logic [31:0] rInit [9] = '{`ASB_RST_CONFIG, `ASB_RST_SAMPLES,
        `ASB_RST_REPEAT, `ASB_RST_LEVEL, `ASB_RST_CLKDIV, 32'h0, 32'h0,
        32'h0, `ASB_RST_RINGBACK};
    asb_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convIn(convIn), .convStart(convStart), .trigPin(trigPin),
        .status(status));
    asb_conv_model conv (.sys_clk(sys_clk), .rst_n(rst_n),
        .convStart(convStart), .latency(latency), .mute(mute),
        .convIn(convIn), .seq(seq));
    //==============================================================
    // clock and hang guard; the ceiling leaves room for the error timeout
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failCount++;
            $display("[ERR] cycle limit expected done seen running");
            giveVerdict();
        end
    end
    //==============================================================
    // shared checking and bus tasks
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        testsRun++;
        if (got !== exp)
        begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(string name, logic [11:0] a, logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    // bounded wait for one status flag, then compare it
    task automatic waitbit(int idx, logic v, int lim);
        int n;
        n = 0;
        while (status[idx] !== v && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk($sformatf("status bit %0d", idx), {31'h0, v}, {31'h0, status[idx]});
    endtask
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    //==============================================================
    // main sequence
    initial
    begin
        {rst_n, psel, penable, pwrite, trigPin, mute} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        latency = 8'h02;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (k = 0; k < 9; k++)
            rdchk("reset value", rAddr[k], rInit[k]);
        xfer(1'b0, 12'h100, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        // fifo run of one repeat, data read back oldest first
        // period of 8 cycles leaves room for the converter round trip
        wr(`ASB_OFS_CLKDIV, 32'h7);
        wr(`ASB_OFS_SAMPLES, 32'h4);
        chk("idle before start", 32'h0, {26'h0, status});
        s0 = seq;
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(0, 1'b1, 4);
        rdchk("status in run", `ASB_OFS_STATUS, 32'h1);
        waitbit(0, 1'b0, 200);
        chk("fifo done", 32'h04, {26'h0, status});
        rdchk("count", `ASB_OFS_COUNT, 32'h4);
        rdchk("repeats", `ASB_OFS_REPCNT, 32'h1);
        for (k = 0; k < 4; k++)
        begin
            rdchk("fifo data", `ASB_OFS_DATA, 32'h8000 + s0 + k);
            waitbit(2, 1'b0, 3);
        end
        rdchk("count drained", `ASB_OFS_COUNT, 32'h0);
        // endless run stopped by command
        wr(`ASB_OFS_REPEAT, 32'h0);
        wr(`ASB_OFS_CTRL, 32'h1);
        repeat (20) @(posedge sys_clk);
        wr(`ASB_OFS_CTRL, 32'h2);
        waitbit(0, 1'b0, 4);
        // fifo overflow halts, memory reset clears
        latency <= 8'h01;
        wr(`ASB_OFS_CTRL, 32'h8);
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(3, 1'b1, 2500);
        waitbit(0, 1'b0, 4);
        rdchk("full count", `ASB_OFS_COUNT, `ASB_DEPTH);
        wr(`ASB_OFS_CTRL, 32'h8);
        rdchk("count cleared", `ASB_OFS_COUNT, 32'h0);
        rdchk("repeats cleared", `ASB_OFS_REPCNT, 32'h0);
        chk("flags cleared", 32'h0, {26'h0, status});
        // ring keeps running past full and keeps read data
        wr(`ASB_OFS_CONFIG, 32'h1);
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(3, 1'b1, 2500);
        chk("ring runs on", 32'h0D, {26'h0, status});
        wr(`ASB_OFS_CTRL, 32'h2);
        waitbit(0, 1'b0, 4);
        xfer(1'b0, `ASB_OFS_DATA, 32'h0);
        s0 = rd[15:0];
        rdchk("ring reread", `ASB_OFS_DATA, {16'h0, s0});
        rdchk("ring count kept", `ASB_OFS_COUNT, `ASB_DEPTH);
        waitbit(2, 1'b1, 1);
        // external trigger with two repeats
        wr(`ASB_OFS_CTRL, 32'h8);
        wr(`ASB_OFS_CONFIG, 32'h4);
        wr(`ASB_OFS_SAMPLES, 32'h2);
        wr(`ASB_OFS_REPEAT, 32'h2);
        wr(`ASB_OFS_CTRL, 32'h1);
        repeat (10) @(posedge sys_clk);
        chk("waiting", 32'h03, {26'h0, status});
        @(posedge sys_clk) trigPin <= 1'b1;
        waitbit(1, 1'b0, 20);
        waitbit(1, 1'b1, 100);
        rdchk("first repeat", `ASB_OFS_REPCNT, 32'h1);
        @(posedge sys_clk) trigPin <= 1'b0;
        repeat (4) @(posedge sys_clk);
        trigPin <= 1'b1;
        waitbit(0, 1'b0, 100);
        rdchk("all repeats", `ASB_OFS_REPCNT, 32'h2);
        rdchk("two runs", `ASB_OFS_COUNT, 32'h4);
        // level start waits until a code crosses the level
        wr(`ASB_OFS_CTRL, 32'h8);
        wr(`ASB_OFS_CONFIG, 32'h2);
        wr(`ASB_OFS_LEVEL, 32'h8000 + seq + 16'h0008);
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(1, 1'b1, 4);
        waitbit(1, 1'b0, 200);
        wr(`ASB_OFS_CTRL, 32'h2);
        // sampling clock error halts, status reset clears
        wr(`ASB_OFS_CTRL, 32'h8);
        wr(`ASB_OFS_CONFIG, 32'h0);
        wr(`ASB_OFS_CLKDIV, 32'h1);
        latency <= 8'h05;
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(4, 1'b1, 50);
        waitbit(0, 1'b0, 4);
        wr(`ASB_OFS_CTRL, 32'h4);
        waitbit(4, 1'b0, 3);
        // silent converter gives a conversion error
        // slow divider so the watchdog fires before any clock error
        mute <= 1'b1;
        wr(`ASB_OFS_CLKDIV, 32'hFFF);
        wr(`ASB_OFS_CTRL, 32'h1);
        waitbit(5, 1'b1, 6500);
        waitbit(0, 1'b0, 4);
        wr(`ASB_OFS_CTRL, 32'h4);
        waitbit(5, 1'b0, 3);
        giveVerdict();
    end
endmodule
